/* rtl/ddr_seq_params.svh */
// offsets, field layout, reset values, commands and timing counts for the sequencer
// assumes a 50 MHz system clock; every time below is turned into cycles here, except the refresh interval, which becomes ticks of 16 cycles
`ifndef DDR_SEQ_PARAMS_SVH
`define DDR_SEQ_PARAMS_SVH

`define CLK_PERIOD_NS   20
// register byte offsets on the plain register port
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_REFRESH     8'h08
// ctrl: [7:0] wait cycles, [10:8] burst code, [13:11] cas latency,
// [15:14] recapture phase, [16] quarter-phase write clock select
`define CTRL_W          17
`define CTRL_RST        17'h01910
`define REF_TICKS_W     8
// refresh interval, in ticks of the divided clock
`define T_REFI_NS       15600
`define REF_DIV         16
`define REF_TICKS_RST   8'((`T_REFI_NS) / ((`CLK_PERIOD_NS) * (`REF_DIV)))
// least times, rounded up to whole cycles
`define T_RP_NS         15
`define T_RCD_NS        15
`define T_RFC_NS        72
`define T_RP_CYC        4'(((`T_RP_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define T_RCD_CYC       4'(((`T_RCD_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define T_RFC_CYC       4'(((`T_RFC_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
// memory commands as {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP         4'h7
`define CMD_ACT         4'h3
`define CMD_READ        4'h5
`define CMD_WRITE       4'h4
`define CMD_PRE         4'h2
`define CMD_REF         4'h1
// burst length codes
`define BL_CODE_4       3'h2
`define BL_CODE_8       3'h3
// depths of the read-side structures
`define EXP_DEPTH       16
`define RFIFO_DEPTH     4

`endif

/* rtl/ddr_seq_pkg.sv */
// types shared by the sequencer and whoever instantiates it
// assumes the constants header is compiled alongside
package ddr_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_PRECHARGE, ST_ACTIVE, ST_WRITE, ST_WRITE_WAIT,
    ST_READ, ST_READ_WAIT, ST_CLOSE
  } seq_state_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } mem_cmd_s;

  typedef struct packed {
    logic [11:0] row;
    logic [7:0]  col;
    logic [1:0]  bank;
  } req_addr_s;

  typedef struct packed {
    logic [31:0] rise_d;
    logic [31:0] fall_d;
    logic [3:0]  rise_m;
    logic [3:0]  fall_m;
  } wr_entry_s;

  typedef struct packed {
    logic [31:0] rise_d;
    logic [31:0] fall_d;
  } rd_word_s;

  typedef struct packed {
    logic       wclk_en;
    logic [1:0] phase;
    logic [2:0] cas;
    logic [2:0] bl;
    logic [7:0] wait_cycles;
  } ctrl_s;
endpackage

/* rtl/ddr_access_sequencer.sv */
// read/write sequencer and datapath of a ddr sdram controller
// assumes show-ahead request fifos outside, with occupancy counts, and ddr pad flops outside
//
// What this block does
// [RULE1] write pending when write address fifo non-empty
// [RULE2] row/bank mismatch: precharge, activate, then access
// [RULE3] pop write data, register twice, issue writes
// [RULE4] repeat writes until write address fifo is empty
// [RULE5] take writes in idle, write, read wait
// [RULE6] post-write wait, then close bank, idle, refresh
// [RULE7] read pending when read address fifo non-empty
// [RULE8] take reads in idle, read wait, write wait
// [RULE9] issue reads until read address fifo empty
// [RULE10] post-read wait, then close bank, idle, refresh
// [RULE11] no priority arbitration between reads and writes; idle here takes writes before reads
// [RULE12] divide clock by sixteen for refresh counter
// [RULE13] recapture phase is a programmable setting
// [RULE14] strobe enable and strobe reset during writes
// [RULE15] strobe reset released after one cycle
// [RULE16] data output enable only during write transfers
// [RULE17] strobe and memory clock from ddr flops
// [RULE18] read return pipelined to align with commands
// [RULE19] returned strobe qualifies capture of read data
// [RULE20] captured data passes through recapture fifo
// [RULE21] two register stages between capture and system
// [RULE22] optional quarter-phase clock for write data
// [RULE23] address entry is row, column, bank
// [RULE24] one, two or four entries per burst
// [RULE25] write entry is data rise, fall, masks
// [RULE26] wait counter restarts on same-direction request
// [RULE27] refresh only serviced from idle
`timescale 1ns/10ps
`include "ddr_seq_params.svh"

module ddr_access_sequencer
  import ddr_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // request fifos: occupancy, head entry, pop
  input  wire logic [4:0]  wr_addr_cnt,
  input  wire req_addr_s   wr_addr_head,
  output logic             wr_addr_pop,
  input  wire logic [4:0]  wr_data_cnt,
  input  wire wr_entry_s   wr_data_head,
  output logic             wr_data_pop,
  input  wire logic [4:0]  rd_addr_cnt,
  input  wire req_addr_s   rd_addr_head,
  output logic             rd_addr_pop,
  // read data to the user
  output rd_word_s         rd_data,
  output logic             rd_data_valid,
  // memory command side
  output mem_cmd_s         mem_cmd,
  output logic [11:0]      mem_addr,
  output logic [1:0]       mem_ba,
  output logic             mem_cke,
  output logic             mem_ck_rise,
  output logic             mem_ck_fall,
  // write datapath to ddr output flops
  output wr_entry_s        dq_out,
  output logic             dq_oe,
  output logic             dq_quarter_phase,
  output logic             dqs_rise,
  output logic             dqs_fall,
  output logic             dqs_oe,
  output logic             dqs_rst,
  // read datapath from ddr input flops
  input  wire rd_word_s    dq_in,
  input  wire logic        dqs_in
);

  // ---- state ----
  seq_state_e  state_ff, state_nxt;                 // sequencer state
  logic [3:0]  gap_ff, gap_nxt;                     // command spacing counter
  logic [2:0]  beats_ff, beats_nxt;                 // remaining entries of a burst
  logic [7:0]  wait_ff, wait_nxt;                   // post-burst idle counter
  logic        dir_wr_ff, dir_wr_nxt;               // direction of the current run
  logic        open_ff, open_nxt;                   // a row is open
  logic [11:0] open_row_ff, open_row_nxt;           // open row
  logic [1:0]  open_bank_ff, open_bank_nxt;         // open bank
  mem_cmd_s    cmd_nxt;                             // command to drive next
  logic [11:0] addr_nxt;                            // address to drive next
  logic [1:0]  ba_nxt;                              // bank to drive next
  logic        wap_nxt, wdp_nxt, rap_nxt;           // pops to drive next
  logic        ref_clr;                             // refresh issued this cycle
  logic        rd_beat;                             // a read beat is expected
  ctrl_s       ctrl_ff;                             // control register
  logic [7:0]  ref_ticks_ff;                        // refresh interval setting
  logic        ref_pend_ff;                         // refresh owed
  logic [3:0]  div_ff;                              // divide-by-sixteen prescaler
  logic [7:0]  ref_cnt_ff;                          // ticks since last refresh
  wr_entry_s   wstage_ff;                           // write data, first stage
  logic        wstage_v_ff;                         // first stage holds a beat
  logic [`EXP_DEPTH-1:0] exp_ff;                    // read beat alignment line
  rd_word_s    cap_ff, sync1_ff, sync2_ff;          // capture and two sync stages
  logic        cap_v_ff, sync1_v_ff, sync2_v_ff;    // their valids
  rd_word_s    rfifo_mem [`RFIFO_DEPTH];            // recapture fifo storage
  logic [2:0]  rf_wp_ff, rf_rp_ff;                  // fifo pointers, wrap bit on top

  // head of a fifo is stale in the cycle its pop is driven
  logic        wr_req, rd_req, wr_dat, wr_hit, rd_hit;
  logic [2:0]  burst_m1;
  logic [3:0]  tap;
  assign wr_req   = (wr_addr_cnt != 5'h00) && !wr_addr_pop;    // RULE1
  assign rd_req   = (rd_addr_cnt != 5'h00) && !rd_addr_pop;    // RULE7
  assign wr_dat   = wr_data_cnt > {4'h0, wr_data_pop};
  // entry fields are read in row, column, bank order
  assign wr_hit   = open_ff && wr_addr_head.row == open_row_ff
                    && wr_addr_head.bank == open_bank_ff;      // RULE2 RULE23
  assign rd_hit   = open_ff && rd_addr_head.row == open_row_ff
                    && rd_addr_head.bank == open_bank_ff;      // RULE2
  // one, two or four entries make a burst of two, four, eight
  assign burst_m1 = (ctrl_ff.bl == `BL_CODE_8) ? 3'h3 :
                    (ctrl_ff.bl == `BL_CODE_4) ? 3'h1 : 3'h0;  // RULE24
  assign tap      = 4'(ctrl_ff.cas) + 4'(ctrl_ff.phase);       // RULE13 RULE18

  // next-state and command decode; idle takes writes before reads, and a run keeps its direction while it has requests
  always_comb begin // RULE11
    state_nxt     = state_ff;
    gap_nxt       = (gap_ff != 4'h0) ? gap_ff - 4'h1 : 4'h0;
    beats_nxt     = beats_ff;
    wait_nxt      = wait_ff;
    dir_wr_nxt    = dir_wr_ff;
    open_nxt      = open_ff;
    open_row_nxt  = open_row_ff;
    open_bank_nxt = open_bank_ff;
    cmd_nxt       = `CMD_NOP;
    addr_nxt      = 12'h000;
    ba_nxt        = open_bank_ff;
    wap_nxt       = 1'b0;
    wdp_nxt       = 1'b0;
    rap_nxt       = 1'b0;
    ref_clr       = 1'b0;
    rd_beat       = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (gap_ff == 4'h0) begin
          if (ref_pend_ff) begin // RULE27
            cmd_nxt = `CMD_REF;
            gap_nxt = `T_RFC_CYC - 4'h1;
            ref_clr = 1'b1;
          end else if (wr_req) begin // RULE5
            dir_wr_nxt = 1'b1;
            state_nxt  = wr_hit ? ST_WRITE : (open_ff ? ST_PRECHARGE : ST_ACTIVE);
          end else if (rd_req) begin // RULE8
            dir_wr_nxt = 1'b0;
            state_nxt  = rd_hit ? ST_READ : (open_ff ? ST_PRECHARGE : ST_ACTIVE);
          end
        end
      end
      ST_PRECHARGE: begin
        // close the conflicting row before opening the wanted one
        if (gap_ff == 4'h0) begin // RULE2
          cmd_nxt   = `CMD_PRE;
          open_nxt  = 1'b0;
          gap_nxt   = `T_RP_CYC - 4'h1;
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (gap_ff == 4'h0) begin // RULE2
          cmd_nxt       = `CMD_ACT;
          addr_nxt      = dir_wr_ff ? wr_addr_head.row : rd_addr_head.row;
          ba_nxt        = dir_wr_ff ? wr_addr_head.bank : rd_addr_head.bank;
          open_nxt      = 1'b1;
          open_row_nxt  = addr_nxt;
          open_bank_nxt = ba_nxt;
          gap_nxt       = `T_RCD_CYC - 4'h1;
          state_nxt     = dir_wr_ff ? ST_WRITE : ST_READ;
        end
      end
      ST_WRITE: begin
        if (beats_ff != 3'h0) begin
          // later entries of the burst; a dry data fifo stalls the beat
          if (wr_dat) begin // RULE3
            wdp_nxt   = 1'b1;
            beats_nxt = beats_ff - 3'h1;
          end
        end else if (gap_ff == 4'h0) begin
          if (wr_req) begin // RULE4
            if (!wr_hit) begin
              state_nxt = ST_PRECHARGE; // RULE2
            end else if (wr_dat) begin // RULE3
              cmd_nxt   = `CMD_WRITE;
              addr_nxt  = {4'h0, wr_addr_head.col};
              ba_nxt    = wr_addr_head.bank;
              wap_nxt   = 1'b1;
              wdp_nxt   = 1'b1;
              beats_nxt = burst_m1;
            end
          end else if (!wr_addr_pop) begin
            wait_nxt  = 8'h00;
            state_nxt = ST_WRITE_WAIT; // RULE6
          end
        end
      end
      ST_WRITE_WAIT: begin
        if (wr_req) begin // RULE5 RULE26
          state_nxt = wr_hit ? ST_WRITE : ST_PRECHARGE;
        end else if (rd_req) begin // RULE8
          dir_wr_nxt = 1'b0;
          state_nxt  = rd_hit ? ST_READ : ST_PRECHARGE;
        end else if (wait_ff >= ctrl_ff.wait_cycles) begin
          state_nxt = ST_CLOSE; // RULE6
        end else begin
          wait_nxt = wait_ff + 8'h01;
        end
      end
      ST_READ: begin
        if (beats_ff != 3'h0) begin
          // hold the bus while the burst returns so bursts do not overlap
          beats_nxt = beats_ff - 3'h1;
          rd_beat   = 1'b1;
        end else if (gap_ff == 4'h0) begin
          if (rd_req) begin // RULE9
            if (!rd_hit) begin
              state_nxt = ST_PRECHARGE; // RULE2
            end else begin
              cmd_nxt   = `CMD_READ;
              addr_nxt  = {4'h0, rd_addr_head.col};
              ba_nxt    = rd_addr_head.bank;
              rap_nxt   = 1'b1;
              rd_beat   = 1'b1;
              beats_nxt = burst_m1;
            end
          end else if (!rd_addr_pop) begin
            wait_nxt  = 8'h00;
            state_nxt = ST_READ_WAIT; // RULE10
          end
        end
      end
      ST_READ_WAIT: begin
        if (rd_req) begin // RULE8 RULE26
          state_nxt = rd_hit ? ST_READ : ST_PRECHARGE;
        end else if (wr_req) begin // RULE5
          dir_wr_nxt = 1'b1;
          state_nxt  = wr_hit ? ST_WRITE : ST_PRECHARGE;
        end else if (wait_ff >= ctrl_ff.wait_cycles) begin
          state_nxt = ST_CLOSE; // RULE10
        end else begin
          wait_nxt = wait_ff + 8'h01;
        end
      end
      ST_CLOSE: begin
        // close the bank; idle then services any owed refresh
        if (gap_ff == 4'h0) begin // RULE6 RULE10
          cmd_nxt   = `CMD_PRE;
          open_nxt  = 1'b0;
          gap_nxt   = `T_RP_CYC - 4'h1;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff     <= ST_IDLE;
      gap_ff       <= 4'h0;
      beats_ff     <= 3'h0;
      wait_ff      <= 8'h00;
      dir_wr_ff    <= 1'b0;
      open_ff      <= 1'b0;
      open_row_ff  <= 12'h000;
      open_bank_ff <= 2'h0;
    end else begin
      state_ff     <= state_nxt;
      gap_ff       <= gap_nxt;
      beats_ff     <= beats_nxt;
      wait_ff      <= wait_nxt;
      dir_wr_ff    <= dir_wr_nxt;
      open_ff      <= open_nxt;
      open_row_ff  <= open_row_nxt;
      open_bank_ff <= open_bank_nxt;
    end
  end

  // command pins and fifo pops, all registered
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_cmd     <= `CMD_NOP;
      mem_addr    <= 12'h000;
      mem_ba      <= 2'h0;
      mem_cke     <= 1'b0;
      wr_addr_pop <= 1'b0;
      wr_data_pop <= 1'b0;
      rd_addr_pop <= 1'b0;
    end else begin
      mem_cmd     <= cmd_nxt;
      mem_addr    <= addr_nxt;
      mem_ba      <= ba_nxt;
      mem_cke     <= 1'b1;
      wr_addr_pop <= wap_nxt;
      wr_data_pop <= wdp_nxt;
      rd_addr_pop <= rap_nxt;
    end
  end

  // refresh timing: prescaler stands in for the divided_refresh_clock so that all
  // logic stays on one clock; the owed flag lets a new request win over the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      div_ff      <= 4'h0;
      ref_cnt_ff  <= 8'h00;
      ref_pend_ff <= 1'b0;
    end else begin
      div_ff <= div_ff + 4'h1; // RULE12
      if (div_ff == 4'(`REF_DIV - 1)) begin // RULE12
        if (ref_cnt_ff >= ref_ticks_ff - 8'h01) begin
          ref_cnt_ff  <= 8'h00;
          ref_pend_ff <= 1'b1;
        end else begin
          ref_cnt_ff  <= ref_cnt_ff + 8'h01;
          ref_pend_ff <= ref_pend_ff & ~ref_clr;
        end
      end else begin
        ref_pend_ff <= ref_pend_ff & ~ref_clr; // RULE27
      end
    end
  end

  // write datapath: popped entry lands in a stage register, then the ddr output flops
  always_ff @(posedge clk) begin
    if (srst) begin
      wstage_ff        <= '0;
      wstage_v_ff      <= 1'b0;
      dq_out           <= '0;
      dq_oe            <= 1'b0;
      dq_quarter_phase <= 1'b0;
      dqs_oe           <= 1'b0;
      dqs_rst          <= 1'b0;
      dqs_rise         <= 1'b0;
      dqs_fall         <= 1'b0;
      mem_ck_rise      <= 1'b0;
      mem_ck_fall      <= 1'b0;
    end else begin
      if (wr_data_pop) begin
        wstage_ff <= wr_data_head; // RULE3 RULE25
      end
      wstage_v_ff      <= wr_data_pop;
      dq_out           <= wstage_ff; // RULE3
      dq_oe            <= wstage_v_ff; // RULE16
      // pad flops for dq move to the quarter-phase clock to centre the strobe
      dq_quarter_phase <= ctrl_ff.wclk_en; // RULE22
      // preamble cycle: enable with the strobe flop held cleared
      dqs_oe           <= wr_data_pop | wstage_v_ff; // RULE14
      dqs_rst          <= wr_data_pop & ~dqs_oe & ~wstage_v_ff; // RULE14 RULE15
      // clock and strobe share the same 1/0 ddr flop pattern so they stay aligned
      dqs_rise         <= 1'b1; // RULE17
      dqs_fall         <= 1'b0;
      mem_ck_rise      <= 1'b1; // RULE17
      mem_ck_fall      <= 1'b0;
    end
  end

  // read return: expected-beat line, strobe-qualified capture, two stages into the fifo
  always_ff @(posedge clk) begin
    if (srst) begin
      exp_ff     <= '0;
      cap_ff     <= '0;
      cap_v_ff   <= 1'b0;
      sync1_ff   <= '0;
      sync1_v_ff <= 1'b0;
      sync2_ff   <= '0;
      sync2_v_ff <= 1'b0;
      rf_wp_ff   <= 3'h0;
    end else begin
      exp_ff     <= {exp_ff[`EXP_DEPTH-2:0], rd_beat}; // RULE18
      // a beat is only taken when the memory's strobe is present
      cap_v_ff   <= exp_ff[tap] & dqs_in; // RULE19
      if (exp_ff[tap] & dqs_in) begin
        cap_ff <= dq_in; // RULE19
      end
      sync1_ff   <= cap_ff; // RULE21
      sync1_v_ff <= cap_v_ff;
      sync2_ff   <= sync1_ff; // RULE21
      sync2_v_ff <= sync1_v_ff;
      if (sync2_v_ff) begin
        rf_wp_ff <= rf_wp_ff + 3'h1; // RULE20
      end
    end
  end

  // recapture fifo storage; no reset needed on the data words
  always_ff @(posedge clk) begin
    if (sync2_v_ff) begin
      rfifo_mem[rf_wp_ff[1:0]] <= sync2_ff; // RULE20
    end
  end

  // drain side: never stalled, so the fifo cannot overflow
  always_ff @(posedge clk) begin
    if (srst) begin
      rf_rp_ff      <= 3'h0;
      rd_data       <= '0;
      rd_data_valid <= 1'b0;
    end else begin
      rd_data_valid <= rf_wp_ff != rf_rp_ff;
      if (rf_wp_ff != rf_rp_ff) begin
        rd_data  <= rfifo_mem[rf_rp_ff[1:0]]; // RULE20
        rf_rp_ff <= rf_rp_ff + 3'h1;
      end
    end
  end

  // register port: writes take effect next edge, reads answer one cycle later
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff      <= `CTRL_RST;
      ref_ticks_ff <= `REF_TICKS_RST;
      reg_rdata    <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == `REG_CTRL) begin
        ctrl_ff <= reg_wdata[`CTRL_W-1:0]; // RULE13 RULE22
      end
      if (reg_wr && reg_addr == `REG_REFRESH) begin
        ref_ticks_ff <= reg_wdata[`REF_TICKS_W-1:0];
      end
      case (reg_addr)
        `REG_CTRL:    reg_rdata <= reg_rd ? {15'h0000, ctrl_ff} : 32'h0000_0000;
        `REG_STATUS:  reg_rdata <= reg_rd ? {12'h000, open_row_ff, open_bank_ff,
                                              ref_pend_ff, open_ff, state_ff}
                                          : 32'h0000_0000;
        `REG_REFRESH: reg_rdata <= reg_rd ? {24'h000000, ref_ticks_ff} : 32'h0000_0000;
        default:      reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---- checks ----
  sequence s_pre_from_conflict;
    state_ff == ST_PRECHARGE && gap_ff == 4'h0;
  endsequence
  sequence s_act_out;
    ##[2:6] mem_cmd == `CMD_ACT;
  endsequence
  property p_conflict_order;
    @(posedge clk) disable iff (srst) s_pre_from_conflict |-> s_act_out;
  endproperty
  a_conflict_order: assert property (p_conflict_order) else $error("no activate after precharge"); // RULE2

  property p_wr_detect;
    @(posedge clk) disable iff (srst)
      state_ff == ST_IDLE && gap_ff == 4'h0 && !ref_pend_ff && wr_req |=> state_ff != ST_IDLE;
  endproperty
  a_wr_detect: assert property (p_wr_detect) else $error("write request ignored in idle"); // RULE1

  property p_rd_detect;
    @(posedge clk) disable iff (srst)
      state_ff == ST_WRITE_WAIT && !wr_req && rd_req |=> !dir_wr_ff;
  endproperty
  a_rd_detect: assert property (p_rd_detect) else $error("read request ignored in write wait"); // RULE8

  sequence s_pop_then_stage;
    wr_data_pop ##1 wstage_v_ff;
  endsequence
  property p_write_data_path;
    @(posedge clk) disable iff (srst) s_pop_then_stage |=> dq_oe && dqs_oe;
  endproperty
  a_write_data_path: assert property (p_write_data_path) else $error("write beat not driven"); // RULE3

  property p_preamble;
    @(posedge clk) disable iff (srst) dqs_rst |-> dqs_oe ##1 !dqs_rst && dqs_oe;
  endproperty
  a_preamble: assert property (p_preamble) else $error("strobe reset not released"); // RULE15

  property p_dq_oe_only_write;
    @(posedge clk) disable iff (srst) dq_oe |-> $past(wr_data_pop, 2);
  endproperty
  a_dq_oe_only_write: assert property (p_dq_oe_only_write) else $error("dq driven off write"); // RULE16

  property p_refresh_idle;
    @(posedge clk) disable iff (srst) mem_cmd == `CMD_REF |-> $past(state_ff) == ST_IDLE;
  endproperty
  a_refresh_idle: assert property (p_refresh_idle) else $error("refresh outside idle"); // RULE27

  property p_wait_close;
    @(posedge clk) disable iff (srst)
      state_ff == ST_READ_WAIT && !rd_req && !wr_req && wait_ff >= ctrl_ff.wait_cycles
      |=> state_ff == ST_CLOSE ##[1:4] mem_cmd == `CMD_PRE;
  endproperty
  a_wait_close: assert property (p_wait_close) else $error("bank not closed after wait"); // RULE10

  property p_sync_two_stage;
    @(posedge clk) disable iff (srst) cap_v_ff |-> ##2 sync2_v_ff;
  endproperty
  a_sync_two_stage: assert property (p_sync_two_stage) else $error("capture not double registered"); // RULE21

endmodule

/* verification/ddr_mem_model.sv */
// memory device stand-in: answers read commands on the captured data lines
// assumes cas 3, recapture phase 0 and one beat per read command
`timescale 1ns/10ps
`include "ddr_seq_params.svh"

module ddr_mem_model
  import ddr_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire mem_cmd_s    mem_cmd,
  input  wire logic [11:0] mem_addr,
  output rd_word_s         dq_in,
  output logic             dqs_in
);
  logic [2:0] rd_pipe = 3'h0;  // read command delay line
  logic [7:0] c1, c2, c3;      // column riding along with each beat
  logic [7:0] col;             // column of the beat now due

  // the beat lands three cycles after its command
  always @(posedge clk) begin
    rd_pipe <= {rd_pipe[1:0], mem_cmd == `CMD_READ};
    c1 <= mem_addr[7:0];
    c2 <= c1;
    c3 <= c2;
  end

  assign col = c3;
  // strobe only with a beat; a released bus shows the inverse, never a stale word
  assign dqs_in = rd_pipe[2];
  assign dq_in = rd_pipe[2] ? {24'h0, col, ~{24'h0, col}} : {~{24'h0, col}, 24'h0, col};
endmodule

/* verification/ddr_access_sequencer_tb.sv */
// self-checking bench for the access sequencer
// assumes request fifos are modelled here as queues and the memory model sits on the pins
`timescale 1ns/10ps
`include "ddr_seq_params.svh"

module ddr_access_sequencer_tb
  import ddr_seq_pkg::*;
;
  logic        clk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [4:0]  wr_addr_cnt = 0, wr_data_cnt = 0, rd_addr_cnt = 0;
  req_addr_s   wr_addr_head = 0, rd_addr_head = 0, waq[$], raq[$];
  wr_entry_s   wr_data_head = 0, dq_out, wdq[$], wexp[$];
  rd_word_s    rd_data, dq_in, rexp[$];
  mem_cmd_s    mem_cmd, cmds[$];
  logic [11:0] mem_addr, adrs[$];
  logic [1:0]  mem_ba;
  logic        wr_addr_pop, wr_data_pop, rd_addr_pop, rd_data_valid, mem_cke, mem_ck_rise;
  logic        mem_ck_fall, dq_oe, dq_quarter_phase, dqs_rise, dqs_fall, dqs_oe, dqs_rst, dqs_in;
  int          miscompares = 0, total_checks = 0;
  int          refs = 0, cyc = 0, tms[$];  // refresh count, edge count, cycle of each non-refresh command
  logic [3:0]  seq [7] = '{`CMD_ACT, `CMD_WRITE, `CMD_PRE, `CMD_ACT, `CMD_WRITE, `CMD_READ, `CMD_PRE};
  // row on activate, column on access, zero on precharge
  logic [11:0] ads [7] = '{12'h001, 12'h010, 12'h000, 12'h002, 12'h020, 12'h030, 12'h000};

  always #10 clk = ~clk;

  ddr_access_sequencer dut_u (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .wr_addr_cnt, .wr_addr_head, .wr_addr_pop, .wr_data_cnt, .wr_data_head, .wr_data_pop,
    .rd_addr_cnt, .rd_addr_head, .rd_addr_pop, .rd_data, .rd_data_valid, .mem_cmd, .mem_addr,
    .mem_ba, .mem_cke, .mem_ck_rise, .mem_ck_fall, .dq_out, .dq_oe, .dq_quarter_phase,
    .dqs_rise, .dqs_fall, .dqs_oe, .dqs_rst, .dq_in, .dqs_in);
  ddr_mem_model mem_u (.clk, .mem_cmd, .mem_addr, .dq_in, .dqs_in);

  task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk("reg_rdata", 72'(e), 72'(reg_rdata));
    @(posedge clk);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // show-ahead fifos: a pop removes the head at the end of its cycle; empty heads scrambled
  always @(posedge clk) begin
    if (wr_addr_pop) void'(waq.pop_front());
    if (wr_data_pop) void'(wdq.pop_front());
    if (rd_addr_pop) void'(raq.pop_front());
    wr_addr_cnt <= 5'(waq.size());
    wr_data_cnt <= 5'(wdq.size());
    rd_addr_cnt <= 5'(raq.size());
    wr_addr_head <= waq.size() ? waq[0] : ~22'h0;
    wr_data_head <= wdq.size() ? wdq[0] : ~72'h0;
    rd_addr_head <= raq.size() ? raq[0] : ~22'h0;
  end

  // log commands with address and cycle, count refreshes, compare beats and read words
  always @(posedge clk) if (!srst) begin
    cyc++;
    if (mem_cmd == `CMD_REF) refs++;
    if (mem_cmd != `CMD_NOP && mem_cmd != `CMD_REF) begin
      cmds.push_back(mem_cmd);
      adrs.push_back(mem_addr);
      tms.push_back(cyc);
    end
    if (dq_oe) chk("dq_out", wexp.pop_front(), dq_out);
    if (rd_data_valid) chk("rd_data", 72'(rexp.pop_front()), 72'(rd_data));
  end

  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    #1 chk("mem_cmd", 72'(`CMD_NOP), 72'(mem_cmd));
    // cke up, clock and strobe flops fed the same 1/0 pattern
    chk("clock pins", 72'(5'h1a), 72'({mem_cke, mem_ck_rise, mem_ck_fall, dqs_rise, dqs_fall}));
    @(posedge clk);
    reg_read(`REG_CTRL, 32'(`CTRL_RST));
    reg_read(8'h0c, 32'h0);
    // wait count 8, burst of two, cas 3, quarter-phase write clock on
    reg_write(`REG_CTRL, 32'h00011908);
    reg_read(`REG_CTRL, 32'h00011908);
    // short refresh interval so a refresh falls due in the middle of the run
    reg_write(`REG_REFRESH, 32'h00000002);
    reg_read(`REG_REFRESH, 32'h00000002);
    // two writes to different rows of one bank, then a read of the open row
    waq = '{'{12'h001, 8'h10, 2'h0}, '{12'h002, 8'h20, 2'h0}};
    wdq = '{{32'h11111111, 32'h22222222, 4'h1, 4'h2}, {32'h33333333, 32'h44444444, 4'h4, 4'h8}};
    wexp = wdq;
    raq = '{'{12'h002, 8'h30, 2'h0}};
    rexp = '{{32'h30, ~32'h30}};
    for (int i = 0; i < 400 && cmds.size() < 7; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    foreach (seq[i]) chk("cmd", 72'(seq[i]), 72'(cmds[i]));
    foreach (ads[i]) chk("cmd addr", 72'(ads[i]), 72'(adrs[i]));
    // wait count plus pop, exit, expiry and close cycles between last read and precharge
    chk("close gap", 72'(8 + 4), 72'(tms[6] - tms[5]));
    chk("refresh seen", 72'(1'b1), 72'(refs != 0));
    chk("quarter phase", 72'(1'b1), 72'(dq_quarter_phase));
    chk("cmd count", 72'(7), 72'(cmds.size()));
    chk("writes left", 72'(0), 72'(wexp.size()));
    chk("reads left", 72'(0), 72'(rexp.size()));
    report_and_stop();
  end

  // watchdog against a hang
  initial begin
    #40000;
    miscompares++;
    report_and_stop();
  end
endmodule
